// ---- hdl/otgpd_pkg.sv ----
package otgpd_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned ID_DEBOUNCE_NS = 10000;
	localparam int unsigned ID_DEBOUNCE_CYC =
		(ID_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DEB_W = 11;
	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(ID_DEBOUNCE_CYC - 1);

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam logic [ADDR_W-1:0] MODE_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] CARKIT_ADDR = 4'h1;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h2;

	// Mode register fields.
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned MODE_MSB = 1;
	localparam int unsigned SUSPEND_BIT = 2;
	localparam int unsigned DZ_STYLE_BIT = 3;
	localparam int unsigned UART_PIN_BIT = 4;
	localparam int unsigned OE_INT_EN_BIT = 5;
	localparam int unsigned CS_DISABLE_BIT = 6;
	localparam logic [5:0] MODE_RST = 6'h00;
	localparam logic CS_DISABLE_RST = 1'b1;

	localparam logic [1:0] LINK_USB = 2'h0;
	localparam logic [1:0] LINK_UART = 2'h1;
	localparam logic [1:0] LINK_AUDIO = 2'h2;

	// Car-kit register fields.
	localparam int unsigned CK_EN_BIT = 0;
	localparam int unsigned CK_THRESH_BIT = 1;
	localparam int unsigned CK_POL_BIT = 2;
	localparam logic [2:0] CARKIT_RST = 3'h0;

	// Status register fields.
	localparam int unsigned ST_GND_BIT = 0;
	localparam int unsigned ST_FLOAT_BIT = 1;
	localparam int unsigned ST_CLASS_LSB = 2;
	localparam int unsigned ST_CLASS_MSB = 3;
	localparam int unsigned ST_IDCHG_BIT = 4;
	localparam int unsigned ST_CKFLAG_BIT = 5;

	localparam logic [1:0] ID_NONE = 2'h0;
	localparam logic [1:0] ID_USB = 2'h1;
	localparam logic [1:0] ID_NONUSB = 2'h2;
	localparam logic [1:0] ID_CONFLICT = 2'h3;

	// Positions in the input synchroniser vector.
	localparam int unsigned S_OE_N = 0;
	localparam int unsigned S_PLUS = 1;
	localparam int unsigned S_MINUS = 2;
	localparam int unsigned S_GPIO_TX = 3;
	localparam int unsigned S_RECEIVER_OUTPUT_A = 4;
	localparam int unsigned S_DP = 5;
	localparam int unsigned S_DM = 6;
	localparam int unsigned S_ID_GND = 7;
	localparam int unsigned S_ID_FLT = 8;
	localparam int unsigned S_CK_HI = 9;
	localparam int unsigned S_CK_LO = 10;
	localparam int unsigned N_SYNC = 11;
endpackage : otgpd_pkg

// ---- hdl/otgpd_id_debounce.sv ----
`timescale 1ns/10ps
`default_nettype none
module otgpd_id_debounce (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_gnd,
	input wire logic i_float,
	output logic o_gnd,
	output logic o_float,
	output logic o_change
);
	import otgpd_pkg::*;

	logic [1:0] last;
	logic [DEB_W-1:0] count;
	wire [1:0] sample = {i_float, i_gnd};
	wire moved = (sample != last);
	wire settled = (count == DEB_LAST);
	// A change seen while the count is full restarts the count, so it must
	// not be reported in that same cycle.
	wire take = settled && !moved && (sample != {o_float, o_gnd});

	// A new state must hold for the full count before it is reported.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			last <= 2'h2;
			count <= '0;
			o_gnd <= 1'b0;
			o_float <= 1'b1;
			o_change <= 1'b0;
		end else begin
			last <= sample;
			count <= moved ? '0 : (settled ? count : count + 1'b1);
			o_change <= take;
			if (take) begin
				o_gnd <= sample[0];
				o_float <= sample[1];
			end
		end
	end
endmodule : otgpd_id_debounce
`default_nettype wire

// ---- hdl/otgpd_phy_digital.sv ----
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Classify ID continuously, active or suspended.
// - Status shows debounced live ID comparator states.
// - Clearing disable bit enables ID current source.
// - Grounded ID removal sets disable bit again.
// - Audio mode: lines undriven, car-kit pulses flagged.
// - Threshold select picks one car-kit comparator.
// - Car-kit flag polarity is selectable.
// - UART pin select swaps shared and GPIO pins.
// - Plus/minus transmit drives lines from pins.
// - Data/zero transmit: lines from data and SE0.
// - Receive: lines are inputs, pins driven.
// - Data/zero receive: data follows differential, SE0 decode.
// - Plus/minus receive: pins give line levels.
// - Suspended data/zero: data pin shows D+ level.
// - Suspend USB receive only, receive output floated.
// - Line levels feed the single-ended decoder.
// - UART bridges D+ and D-; suspended floats all.
// - Suspended with enable, OE pin signals interrupt.
// - Suspend powers off the differential receiver.
module otgpd_phy_digital (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [otgpd_pkg::ADDR_W-1:0] i_addr,
	input wire logic [otgpd_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [otgpd_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_plus_data_pin,
	output logic o_plus_data_pin,
	output logic o_plus_data_pin_oe,
	input wire logic i_minus_zero_pin,
	output logic o_minus_zero_pin,
	output logic o_minus_zero_pin_oe,
	output logic o_receiver_output_a_receive_out,
	output logic o_receiver_output_a_receive_out_oe,
	input wire logic i_oe_int_n,
	output logic o_oe_int_n,
	output logic o_oe_int_n_oe,
	input wire logic i_uart_tx_gpio,
	output logic o_uart_rx_gpio,
	output logic o_uart_rx_gpio_oe,
	input wire logic i_receiver_output_a,
	input wire logic i_plus_line_level,
	input wire logic i_minus_line_level,
	output logic o_dp,
	output logic o_dp_oe,
	output logic o_dm,
	output logic o_dm_oe,
	input wire logic i_id_gnd_cmp,
	input wire logic i_id_float_cmp,
	input wire logic i_carkit_high_cmp,
	input wire logic i_carkit_low_cmp,
	output logic o_current_source_en,
	output logic o_receiver_output_a_power_en
);
	import otgpd_pkg::*;

	// Every input here comes from a pin or an analog comparator.
	wire [N_SYNC-1:0] raw = {i_carkit_low_cmp, i_carkit_high_cmp,
		i_id_float_cmp, i_id_gnd_cmp, i_minus_line_level,
		i_plus_line_level, i_receiver_output_a, i_uart_tx_gpio,
		i_minus_zero_pin, i_plus_data_pin, i_oe_int_n};
	logic [N_SYNC-1:0] sync_a;
	logic [N_SYNC-1:0] sync_b;

	genvar gi;
	generate
		for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
			always_ff @(posedge i_mclk) begin
				if (i_srst) begin
					// The OE pin idles high; a zero here would fake a
					// transmit request for two cycles after reset.
					sync_a[gi] <= (gi == S_OE_N);
					sync_b[gi] <= (gi == S_OE_N);
				end else begin
					sync_a[gi] <= raw[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire oe_n_s = sync_b[S_OE_N];
	wire plus_s = sync_b[S_PLUS];
	wire minus_s = sync_b[S_MINUS];
	wire gpio_tx_s = sync_b[S_GPIO_TX];
	wire receiver_output_a_s = sync_b[S_RECEIVER_OUTPUT_A];
	wire dp_s = sync_b[S_DP];
	wire dm_s = sync_b[S_DM];

	// Control and status state.
	logic [5:0] mode_reg;
	logic cs_disable;
	logic [2:0] carkit_reg;
	logic id_changed;
	logic carkit_pulse_flag;
	logic ck_prev;
	logic gnd_prev;

	wire [1:0] link_mode = mode_reg[MODE_MSB:MODE_LSB];
	wire suspend = mode_reg[SUSPEND_BIT];
	wire data_zero_style_select = mode_reg[DZ_STYLE_BIT];
	wire uart_pin_select = mode_reg[UART_PIN_BIT];
	wire oe_int_en = mode_reg[OE_INT_EN_BIT];
	wire carkit_en = carkit_reg[CK_EN_BIT];
	wire carkit_threshold_select = carkit_reg[CK_THRESH_BIT];
	wire carkit_falling = carkit_reg[CK_POL_BIT];

	// Register decode.
	wire wr_mode = i_wr && (i_addr == MODE_ADDR);
	wire wr_carkit = i_wr && (i_addr == CARKIT_ADDR);
	wire wr_status = i_wr && (i_addr == STATUS_ADDR);

	// ID classification runs whatever the power mode is.
	logic id_gnd;
	logic id_float;
	logic id_change;
	otgpd_id_debounce u_id_debounce (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_gnd(sync_b[S_ID_GND]),
		.i_float(sync_b[S_ID_FLT]),
		.o_gnd(id_gnd),
		.o_float(id_float),
		.o_change(id_change)
	);

	wire [1:0] id_class = (id_gnd && id_float) ? ID_CONFLICT :
		id_gnd ? ID_USB : (id_float ? ID_NONE : ID_NONUSB);
	wire gnd_fall = gnd_prev && !id_gnd;

	// Only one comparator is watched at a time.
	wire ck_sel = carkit_threshold_select ? sync_b[S_CK_HI] :
		sync_b[S_CK_LO];
	// Edge polarity is software's choice.
	wire ck_edge = carkit_falling ? (ck_prev && !ck_sel) :
		(!ck_prev && ck_sel);
	wire ck_event = carkit_en && (link_mode == LINK_AUDIO) && ck_edge;

	// Latches clear by writing one; a coinciding event still sets them.
	wire next_id_changed = id_change ||
		(id_changed && !(wr_status && i_wdata[ST_IDCHG_BIT]));
	wire next_ck_flag = ck_event ||
		(carkit_pulse_flag && !(wr_status && i_wdata[ST_CKFLAG_BIT]));
	// Hardware setting wins over a software clear.
	wire next_cs_disable = gnd_fall ||
		(wr_mode ? i_wdata[CS_DISABLE_BIT] : cs_disable);

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mode_reg <= MODE_RST;
			cs_disable <= CS_DISABLE_RST;
			carkit_reg <= CARKIT_RST;
			id_changed <= 1'b0;
			carkit_pulse_flag <= 1'b0;
			ck_prev <= 1'b0;
			gnd_prev <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_reg <= i_wdata[5:0];
			end
			if (wr_carkit) begin
				carkit_reg <= i_wdata[2:0];
			end
			cs_disable <= next_cs_disable;
			id_changed <= next_id_changed;
			carkit_pulse_flag <= next_ck_flag;
			ck_prev <= ck_sel;
			gnd_prev <= id_gnd;
		end
	end

	// Status gives the debounced states live, next to the latches.
	wire [DATA_W-1:0] status_word = {2'h0, carkit_pulse_flag, id_changed,
		id_class, id_float, id_gnd};
	wire [DATA_W-1:0] read_mux =
		(i_addr == MODE_ADDR) ? {1'b0, cs_disable, mode_reg} :
		(i_addr == CARKIT_ADDR) ? {5'h00, carkit_reg} :
		(i_addr == STATUS_ADDR) ? status_word : 8'h00;
	wire [DATA_W-1:0] next_rdata = i_rd ? read_mux : 8'h00;

	// Data path selection.
	wire usb = (link_mode == LINK_USB);
	wire uart_act = (link_mode == LINK_UART) && !suspend;
	wire usb_tx = usb && !suspend && !oe_n_s;
	// Line decode from the two single-ended levels.
	wire rx_zero = !dp_s && !dm_s;
	wire uart_tx_src = uart_pin_select ? gpio_tx_s : minus_s;

	// Lines are driven only in USB transmit or UART; audio leaves them.
	wire next_dp_oe = usb_tx;
	wire next_dm_oe = usb_tx || uart_act;
	wire next_dp = data_zero_style_select ?
		(plus_s && !minus_s) : plus_s;
	wire next_dm = uart_act ? uart_tx_src :
		(data_zero_style_select ? (!plus_s && !minus_s) : minus_s);

	// Controller-side pins drive during any USB receive, suspended too.
	wire usb_rx = usb && !usb_tx;
	wire next_plus_oe = usb_rx || (uart_act && !uart_pin_select);
	wire next_minus_oe = usb_rx;
	// Data follows the differential receiver only while awake.
	wire next_plus_out = (usb && data_zero_style_select && !suspend) ?
		receiver_output_a_s : dp_s;
	wire next_minus_out = data_zero_style_select ? rx_zero : dm_s;
	wire next_gpio_oe = uart_act && uart_pin_select;
	// The differential receive output floats in data/zero and suspend.
	wire next_rcv_oe = usb && !suspend && !data_zero_style_select;

	// OE pin turns into an interrupt output only when asked to.
	wire irq_cond = id_changed || carkit_pulse_flag;
	wire next_oe_pin_oe = suspend && oe_int_en;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
			o_dp <= 1'b0;
			o_dp_oe <= 1'b0;
			o_dm <= 1'b0;
			o_dm_oe <= 1'b0;
			o_plus_data_pin <= 1'b0;
			o_plus_data_pin_oe <= 1'b0;
			o_minus_zero_pin <= 1'b0;
			o_minus_zero_pin_oe <= 1'b0;
			o_receiver_output_a_receive_out <= 1'b0;
			o_receiver_output_a_receive_out_oe <= 1'b0;
			o_uart_rx_gpio <= 1'b0;
			o_uart_rx_gpio_oe <= 1'b0;
			o_oe_int_n <= 1'b1;
			o_oe_int_n_oe <= 1'b0;
			o_current_source_en <= 1'b0;
			o_receiver_output_a_power_en <= 1'b1;
		end else begin
			o_rdata <= next_rdata;
			o_dp <= next_dp;
			o_dp_oe <= next_dp_oe;
			o_dm <= next_dm;
			o_dm_oe <= next_dm_oe;
			o_plus_data_pin <= next_plus_out;
			o_plus_data_pin_oe <= next_plus_oe;
			o_minus_zero_pin <= next_minus_out;
			o_minus_zero_pin_oe <= next_minus_oe;
			o_receiver_output_a_receive_out <= receiver_output_a_s;
			o_receiver_output_a_receive_out_oe <= next_rcv_oe;
			o_uart_rx_gpio <= dp_s;
			o_uart_rx_gpio_oe <= next_gpio_oe;
			o_oe_int_n <= !irq_cond;
			o_oe_int_n_oe <= next_oe_pin_oe;
			o_current_source_en <= !next_cs_disable;
			o_receiver_output_a_power_en <= !suspend;
		end
	end

	// Checks on the registered pins, the car-kit flag, the current source and the debounced ID state.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	sequence s_id_removed;
		gnd_fall;
	endsequence

	sequence s_source_off;
		cs_disable && !o_current_source_en;
	endsequence

	chk_dz_tx_drive: assert property (
		usb_tx && data_zero_style_select |=> o_dp_oe && o_dm_oe &&
		o_dp == ($past(plus_s) && !$past(minus_s)) &&
		o_dm == (!$past(plus_s) && !$past(minus_s)))
		else $error("data/zero transmit drive wrong");

	chk_pm_tx_drive: assert property (
		usb_tx && !data_zero_style_select |=> o_dp == $past(plus_s) &&
		o_dm == $past(minus_s) && o_receiver_output_a_receive_out_oe)
		else $error("plus/minus transmit drive wrong");

	chk_rx_lines_free: assert property (
		usb_rx |=> !o_dp_oe && !o_dm_oe && o_plus_data_pin_oe &&
		o_minus_zero_pin_oe)
		else $error("receive direction wrong");

	chk_dz_rx_decode: assert property (
		usb_rx && data_zero_style_select && !suspend |=>
		o_plus_data_pin == $past(receiver_output_a_s) && !o_receiver_output_a_receive_out_oe &&
		o_minus_zero_pin == (!$past(dp_s) && !$past(dm_s)))
		else $error("data/zero receive decode wrong");

	chk_suspend_plus: assert property (
		usb && suspend |=> o_plus_data_pin == $past(dp_s) &&
		!o_receiver_output_a_receive_out_oe && !o_dp_oe)
		else $error("suspended receive wrong");

	chk_uart_route: assert property (
		uart_act |=> o_dm_oe && !o_dp_oe &&
		o_dm == ($past(uart_pin_select) ? $past(gpio_tx_s) :
		$past(minus_s)) && (o_uart_rx_gpio_oe == $past(uart_pin_select)))
		else $error("UART routing wrong");

	chk_uart_suspend: assert property (
		(link_mode == LINK_UART) && suspend |=> !o_dp_oe && !o_dm_oe &&
		!o_plus_data_pin_oe && !o_minus_zero_pin_oe)
		else $error("suspended UART not floated");

	chk_audio_quiet: assert property (
		(link_mode == LINK_AUDIO) |=> !o_dp_oe && !o_dm_oe)
		else $error("audio mode drives the lines");

	chk_carkit_flag: assert property (
		ck_event |=> carkit_pulse_flag)
		else $error("car-kit pulse not flagged");

	chk_source_reset: assert property (
		s_id_removed |=> s_source_off)
		else $error("current source not switched off");

	chk_oe_int_out: assert property (
		suspend && oe_int_en && irq_cond |=> o_oe_int_n_oe && !o_oe_int_n)
		else $error("interrupt not shown on OE pin");

	chk_id_settle: assert property (
		$rose(id_change) |-> $past(sync_b[S_ID_GND], 2) == id_gnd &&
		$past(sync_b[S_ID_FLT], 2) == id_float)
		else $error("ID status updated without a stable input");
endmodule : otgpd_phy_digital
`default_nettype wire

// ---- bench/otgpd_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module otgpd_ctrl_model (
	input wire logic i_mclk,
	input wire logic i_drive_en,
	input wire logic i_plus,
	input wire logic i_minus,
	input wire logic i_dev_plus,
	input wire logic i_dev_plus_oe,
	input wire logic i_dev_minus,
	input wire logic i_dev_minus_oe,
	output logic o_plus_wire,
	output logic o_minus_wire
);
	logic alt;
	// The shared pins have no keeper, so an idle pin wanders every cycle.
	always_ff @(posedge i_mclk) begin
		alt <= ~(alt === 1'b1);
	end
	// The controller drives the pair while it requests transmit.
	assign o_plus_wire = i_dev_plus_oe ? i_dev_plus
		: (i_drive_en ? i_plus : alt);
	assign o_minus_wire = i_dev_minus_oe ? i_dev_minus
		: (i_drive_en ? i_minus : ~alt);
endmodule : otgpd_ctrl_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import otgpd_pkg::*;
	logic clk, srst, wr, rd, pw, mw, po, poe, mo, moe, rv, rvoe, oo, ooe;
	logic gtx, g, goe, df, sp, sm, dp, dpoe, dm, dmoe, idg, idf, ckh, ckl;
	logic csen, pwen, oen, drv, txp, txm, oew;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d;
	logic [11:0] v;
	logic [23:0] er;
	logic [11:0] corner [4] = '{12'h137, 12'h342, 12'h044, 12'h4CA};
	int n_fail = 0;
	int tests_run = 0;
	int seed = 44;
	int cyc = 0;
	assign oew = ooe ? oo : oen;
	otgpd_phy_digital DUT (.i_mclk(clk), .i_srst(srst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_plus_data_pin(pw), .o_plus_data_pin(po), .o_plus_data_pin_oe(poe),
		.i_minus_zero_pin(mw), .o_minus_zero_pin(mo),
		.o_minus_zero_pin_oe(moe), .o_receiver_output_a_receive_out(rv),
		.o_receiver_output_a_receive_out_oe(rvoe), .i_oe_int_n(oew), .o_oe_int_n(oo),
		.o_oe_int_n_oe(ooe), .i_uart_tx_gpio(gtx), .o_uart_rx_gpio(g),
		.o_uart_rx_gpio_oe(goe), .i_receiver_output_a(df),
		.i_plus_line_level(sp), .i_minus_line_level(sm), .o_dp(dp),
		.o_dp_oe(dpoe), .o_dm(dm), .o_dm_oe(dmoe), .i_id_gnd_cmp(idg),
		.i_id_float_cmp(idf), .i_carkit_high_cmp(ckh),
		.i_carkit_low_cmp(ckl), .o_current_source_en(csen),
		.o_receiver_output_a_power_en(pwen));
	otgpd_ctrl_model partner (.i_mclk(clk), .i_drive_en(drv), .i_plus(txp),
		.i_minus(txm), .i_dev_plus(po), .i_dev_plus_oe(poe),
		.i_dev_minus(mo), .i_dev_minus_oe(moe), .o_plus_wire(pw),
		.o_minus_wire(mw));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	// A hang is cut short well past the longest debounce sequence.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [11:0] e,
		input logic [11:0] s);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= x;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] x);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask : rd_reg
	task automatic rd_chk(input string what, input logic [3:0] a,
		input logic [7:0] e);
		logic [7:0] x;
		rd_reg(a, x);
		chk(what, {4'h0, e}, {4'h0, x});
	endtask : rd_chk
	// Packs {mask, value} over dp, dm, plus, minus, receive and gpio pairs.
	function automatic logic [23:0] exp_path(input logic [11:0] u);
		logic [1:0] lm;
		logic su, dz, sl, on, pl, mi, gt, f, p, m;
		logic [11:0] e, k;
		{lm, su, dz, sl, on, pl, mi, gt, f, p, m} = u;
		e = 12'h000;
		k = 12'hFFF;
		if (lm == LINK_USB && !su && !on) begin
			e[11:8] = {1'h1, dz ? pl & !mi : pl, 1'h1, dz ? !pl & !mi : mi};
			e[3:2] = {!dz, f};
		end else if (lm == LINK_USB) begin
			e[7:4] = {1'h1, (dz && !su) ? f : p, 1'h1, dz ? !p & !m : m};
			e[3:2] = {!dz && !su, f};
		end else if (lm == LINK_UART && !su) begin
			e[9:6] = {1'h1, sl ? gt : mi, !sl, p};
			e[1:0] = {sl, p};
			k[3] = 1'h0;
		end
		k[10] = e[11];
		k[8] = e[9];
		k[6] = e[7];
		k[4] = e[5];
		k[2] = e[3];
		k[0] = e[1];
		return {k, e & k};
	endfunction : exp_path
	initial begin
		{srst, addr, wdata, df, sp, sm} = '1;
		{wr, rd, idg, ckh, ckl, drv, txp, txm, gtx} = '0;
		{idf, oen} = 2'h3;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		#1 chk("reset pins", 12'h001, {10'h0, csen, pwen});
		rd_chk("mode reset", MODE_ADDR, 8'h40);
		rd_chk("status reset", STATUS_ADDR, 8'h02);
		wr_reg(4'hF, 8'hFF);
		rd_chk("unmapped", 4'hF, 8'h00);
		wr_reg(CARKIT_ADDR, 8'hFF);
		rd_chk("carkit rw", CARKIT_ADDR, 8'h07);
		$display("Test registers done");
		wr_reg(MODE_ADDR, 8'h24);
		#1 chk("source on", 12'h001, {11'h0, csen});
		@(posedge clk);
		{idg, idf} <= 2'h2;
		repeat (1000) @(posedge clk);
		rd_chk("id held", STATUS_ADDR, 8'h02);
		repeat (300) @(posedge clk);
		rd_chk("id usb", STATUS_ADDR, 8'h15);
		chk("oe int low", 12'h002, {10'h0, ooe, oo});
		wr_reg(STATUS_ADDR, 8'h10);
		// The pin follows the cleared latch one register stage later.
		@(posedge clk);
		#1 chk("oe int high", 12'h003, {10'h0, ooe, oo});
		@(posedge clk);
		idf <= 1'b1;
		repeat (200) @(posedge clk);
		idf <= 1'b0;
		repeat (1300) @(posedge clk);
		rd_chk("id glitch", STATUS_ADDR, 8'h05);
		idg <= 1'b0;
		repeat (1300) @(posedge clk);
		rd_chk("id nonusb", STATUS_ADDR, 8'h18);
		rd_chk("source auto", MODE_ADDR, 8'h64);
		chk("source off", 12'h000, {11'h0, csen});
		$display("Test id detect done");
		for (int t = 0; t < 4; t++) begin
			wr_reg(MODE_ADDR, 8'h42);
			ckh <= t[1];
			ckl <= t[1];
			wr_reg(CARKIT_ADDR, {5'h0, t[1], t[0], 1'h1});
			repeat (6) @(posedge clk);
			wr_reg(STATUS_ADDR, 8'h30);
			for (int s = 0; s < 2; s++) begin
				if (t[0] ^ s[0]) ckl <= !t[1];
				else ckh <= !t[1];
				repeat (4) @(posedge clk);
				ckh <= t[1];
				ckl <= t[1];
				repeat (6) @(posedge clk);
				rd_reg(STATUS_ADDR, d);
				chk("carkit flag", {11'h0, s[0]}, {11'h0, d[5]});
			end
			chk("audio quiet", 12'h000, {7'h0, dpoe, dmoe, poe, moe, rvoe});
		end
		$display("Test carkit done");
		for (int i = 0; i < 64; i++) begin
			v = (i < 4) ? corner[i] : 12'($random(seed));
			wr_reg(MODE_ADDR, {2'h1, 1'h0, v[7], v[8], v[9], v[11:10]});
			{oen, txp, txm, gtx, df, sp, sm} <= v[6:0];
			drv <= v[11:10] == LINK_UART || (v[11:10] == LINK_USB && !v[9] && !v[6]);
			repeat (8) @(posedge clk);
			#1 er = exp_path(v);
			chk("data path", er[11:0], er[23:12] & {dpoe, dp, dmoe, dm, poe, po,
				moe, mo, rvoe, rv, goe, g});
			chk("receiver_output_a power", {11'h0, !v[9]}, {11'h0, pwen});
		end
		$display("Test data path done");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
